//--- shared/usb_host_port_regs.svh
`ifndef USB_HOST_PORT_REGS_SVH
`define USB_HOST_PORT_REGS_SVH

`define SPACE_BYTES       256
`define CTRL_LOCATIONS    16
`define BUFFER_FIRST      8'h10
`define LOC_CTRL_A        4'h0
`define LOC_BASE_A        4'h1
`define LOC_LEN_A         4'h2
`define LOC_CTRL1         4'h5
`define LOC_IRQ_ENABLE    4'h6
`define LOC_CTRL_B        4'h8
`define LOC_BASE_B        4'h9
`define LOC_LEN_B         4'ha
`define LOC_IRQ_STATUS    4'hd
`define LOC_SOF_LOW_REV   4'he
`define LOC_FULL_FEATURES 4'hf
`define ARM_BIT           0
`define ZERO_BYTE         8'h00
`define HW_REVISION       8'h5a
`define PLL_MULT_48MHZ    3'h1
`define PLL_MULT_12MHZ    3'h4

`endif

//--- shared/usb_host_port_pkg.sv
package usb_host_port_pkg;

    typedef struct packed {
        logic       deviceSelectN;
        logic       readStrobeN;
        logic       writeStrobeN;
        logic       addrSelectLine;
        logic [7:0] data;
    } cpu_pins_type;

    typedef struct packed {
        logic       wrEn;
        logic [7:0] addr;
        logic [7:0] wrData;
    } engine_req_type;

    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] base;
        logic [7:0] len;
    } xfer_set_type;

    typedef enum logic [2:0] {
        IDLE_ST  = 3'b001,
        WRITE_ST = 3'b010,
        READ_ST  = 3'b100
    } access_state_type;

endpackage

//--- rtl/port_buffer_ram.sv
`timescale 1ns/1ps

module port_buffer_ram #(
    parameter int DEPTH = 256
) (
    input  wire logic       clock,
    input  wire logic       cpuWrEn,
    input  wire logic [7:0] cpuAddr,
    input  wire logic [7:0] cpuWrData,
    output logic      [7:0] cpuRdData,
    input  wire logic       engWrEn,
    input  wire logic [7:0] engAddr,
    input  wire logic [7:0] engWrData,
    output logic      [7:0] engRdData
);

    // Contents are unknown after reset, firmware sets them up
    logic [7:0] mem [0:DEPTH-1];

    always_ff @(posedge clock) begin
        if (cpuWrEn) begin
            mem[cpuAddr] <= cpuWrData;
        end
        // Engine loses a same-address collision; the processor owns setup
        if (engWrEn && !(cpuWrEn && cpuAddr == engAddr)) begin
            mem[engAddr] <= engWrData;
        end
    end

    always_ff @(posedge clock) begin
        cpuRdData <= mem[cpuAddr];
        engRdData <= mem[engAddr];
    end

endmodule // port_buffer_ram

//--- rtl/usb_host_cpu_bus_port.sv
`timescale 1ns/1ps
`include "usb_host_port_regs.svh"

// What this block does
// - Processor talks over 8-bit two-way data with select, read, write, address-select.
// - An access ends when its read or write strobe or device select goes inactive, first wins.
// - In indexed mode, each data read or write after one address cycle advances the pointer by one.
// - Space is 256 bytes: 16 control locations, then 240 bytes of packet buffer.
// - Both indexed (auto-advancing) and direct (multiplexed bus) addressing are supported.
// - One interrupt line asserts when an enabled USB activity event occurs.
// - Software enables any event combination and can read pending conditions.
// - Writing ones to the status location clears the matching pending interrupt conditions.
// - Engine moves transaction data in the buffer using programmed pointer and size.
// - Accepts 12 or 48 MHz reference, internal timing derived through a PLL.
// - Any write to the highest control location sets the full-features bit.
module usb_host_cpu_bus_port
    import usb_host_port_pkg::*;
#(
    parameter int         EVENT_COUNT = 8,
    parameter logic [7:0] HW_REV      = `HW_REVISION  // Arbitrary value
) (
    input  wire logic                   clock,
    input  wire logic                   sys_rst,
    input  wire cpu_pins_type           cpuPins,
    output logic [7:0]                  dataOut_r,
    output logic                        dataOeN_r,
    output logic                        irqOut_r,
    input  wire logic                   directAddrMode,
    input  wire logic                   clockFreqSelect,
    output logic [2:0]                  pllMultiplier_r,
    input  wire logic [EVENT_COUNT-1:0] usbEvents,
    input  wire logic                   xferDoneA,
    input  wire logic                   xferDoneB,
    input  wire engine_req_type         engineReq,
    output logic [7:0]                  engineRdData,
    output xfer_set_type                xferSetA_r,
    output xfer_set_type                xferSetB_r,
    output logic                        fullFeatures_r
);

    access_state_type state_r;
    access_state_type state_nxt;
    logic [7:0] pointer_r;
    logic [7:0] wrLatch_r;
    logic       wrAddrCycle_r;
    logic [7:0] ctrlRegs_r [0:`CTRL_LOCATIONS-1];
    logic [EVENT_COUNT-1:0] irqStatus_r;
    logic [7:0] ramRdData;
    logic       writeActive;
    logic       readActive;
    logic       writeCommit;
    logic       readEnd;
    logic       ramWrEn;
    logic       statusClear;

    function automatic logic isCtrl(input logic [7:0] a);
        return a < `BUFFER_FIRST;
    endfunction

    assign writeActive = !cpuPins.deviceSelectN && !cpuPins.writeStrobeN;
    assign readActive  = !cpuPins.deviceSelectN && !cpuPins.readStrobeN;
    assign writeCommit = (state_r == WRITE_ST) && !writeActive;
    assign readEnd     = (state_r == READ_ST) && !readActive;
    assign ramWrEn     = writeCommit && !wrAddrCycle_r && !isCtrl(pointer_r);
    assign statusClear = writeCommit && !wrAddrCycle_r
                       && pointer_r == {4'h0, `LOC_IRQ_STATUS};

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            IDLE_ST: begin
                if (writeActive) begin
                    state_nxt = WRITE_ST;
                end else if (readActive) begin
                    state_nxt = READ_ST;
                end
            end
            WRITE_ST: begin
                if (!writeActive) begin
                    state_nxt = IDLE_ST;
                end
            end
            READ_ST: begin
                if (!readActive) begin
                    state_nxt = IDLE_ST;
                end
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_r <= IDLE_ST;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Data is held until the strobe drops, so keep sampling while active
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            wrLatch_r     <= `ZERO_BYTE;
            wrAddrCycle_r <= 1'b0;
        end else if (writeActive) begin
            wrLatch_r     <= cpuPins.data;
            wrAddrCycle_r <= !cpuPins.addrSelectLine;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            pointer_r <= `ZERO_BYTE;
        end else if (writeCommit && wrAddrCycle_r) begin
            pointer_r <= wrLatch_r;
        end else if ((writeCommit || readEnd) && !directAddrMode) begin
            pointer_r <= pointer_r + 8'h01;
        end
    end

    // Control locations live in flops so the engine can see them every cycle
    genvar g;
    generate
        for (g = 0; g < `CTRL_LOCATIONS; g++) begin : gen_ctrl
            always_ff @(posedge clock) begin
                if (sys_rst) begin
                    ctrlRegs_r[g] <= `ZERO_BYTE;
                end else if (writeCommit && !wrAddrCycle_r && pointer_r == 8'(g)) begin
                    ctrlRegs_r[g] <= wrLatch_r;
                end else if (g == `LOC_CTRL_A && xferDoneA) begin
                    ctrlRegs_r[g][`ARM_BIT] <= 1'b0;
                end else if (g == `LOC_CTRL_B && xferDoneB) begin
                    ctrlRegs_r[g][`ARM_BIT] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            fullFeatures_r <= 1'b0;
        end else if (writeCommit && !wrAddrCycle_r
                     && pointer_r == {4'h0, `LOC_FULL_FEATURES}) begin
            fullFeatures_r <= 1'b1;
        end
    end

    // A new event beats a clear in the same cycle
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            irqStatus_r <= '0;
        end else begin
            irqStatus_r <= (irqStatus_r & ~(statusClear ? wrLatch_r[EVENT_COUNT-1:0] : '0))
                         | usbEvents;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            irqOut_r <= 1'b0;
        end else begin
            irqOut_r <= |(irqStatus_r & ctrlRegs_r[`LOC_IRQ_ENABLE][EVENT_COUNT-1:0]);
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            dataOut_r <= `ZERO_BYTE;
            dataOeN_r <= 1'b1;
        end else begin
            dataOeN_r <= !readActive;
            if (readActive) begin
                if (pointer_r == {4'h0, `LOC_IRQ_STATUS}) begin
                    dataOut_r <= 8'(irqStatus_r);
                end else if (pointer_r == {4'h0, `LOC_SOF_LOW_REV}) begin
                    dataOut_r <= HW_REV;
                end else if (isCtrl(pointer_r)) begin
                    dataOut_r <= ctrlRegs_r[pointer_r[3:0]];
                end else begin
                    dataOut_r <= ramRdData;
                end
            end
        end
    end

    // B set only reaches the engine once extended features are on
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            xferSetA_r <= '0;
            xferSetB_r <= '0;
        end else begin
            xferSetA_r <= '{ctrlRegs_r[`LOC_CTRL_A], ctrlRegs_r[`LOC_BASE_A],
                            ctrlRegs_r[`LOC_LEN_A]};
            xferSetB_r <= fullFeatures_r ? '{ctrlRegs_r[`LOC_CTRL_B], ctrlRegs_r[`LOC_BASE_B],
                            ctrlRegs_r[`LOC_LEN_B]} : '0;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            pllMultiplier_r <= `PLL_MULT_48MHZ;
        end else begin
            // Low selects the 48 MHz reference
            pllMultiplier_r <= clockFreqSelect ? `PLL_MULT_12MHZ : `PLL_MULT_48MHZ;
        end
    end

    port_buffer_ram #(
        .DEPTH (`SPACE_BYTES)
    ) bufferRam (
        .clock     (clock),
        .cpuWrEn   (ramWrEn),
        .cpuAddr   (pointer_r),
        .cpuWrData (wrLatch_r),
        .cpuRdData (ramRdData),
        .engWrEn   (engineReq.wrEn && !isCtrl(engineReq.addr)),
        .engAddr   (engineReq.addr),
        .engWrData (engineReq.wrData),
        .engRdData (engineRdData)
    );

    chk_access_end_write: assert property (@(posedge clock) disable iff (sys_rst)
        (state_r == WRITE_ST && !writeActive) |=> state_r == IDLE_ST)
        else $error("write access did not end");
    chk_pointer_advance: assert property (@(posedge clock) disable iff (sys_rst)
        (readEnd && !directAddrMode) |=> pointer_r == $past(pointer_r) + 8'h01)
        else $error("pointer did not advance");
    chk_direct_hold: assert property (@(posedge clock) disable iff (sys_rst)
        (readEnd && directAddrMode) |=> pointer_r == $past(pointer_r))
        else $error("pointer moved in direct mode");
    chk_address_load: assert property (@(posedge clock) disable iff (sys_rst)
        (writeCommit && wrAddrCycle_r) |=> pointer_r == $past(wrLatch_r))
        else $error("address cycle did not load pointer");
    chk_irq_line: assert property (@(posedge clock) disable iff (sys_rst)
        (usbEvents[0] && ctrlRegs_r[`LOC_IRQ_ENABLE][0]) |-> ##2 irqOut_r)
        else $error("enabled event missed interrupt");
    chk_status_clear: assert property (@(posedge clock) disable iff (sys_rst)
        (statusClear && wrLatch_r[0] && !usbEvents[0]) |=> !irqStatus_r[0])
        else $error("status bit not cleared");
    chk_set_wins: assert property (@(posedge clock) disable iff (sys_rst)
        usbEvents[0] |=> irqStatus_r[0])
        else $error("event lost");
    chk_full_features: assert property (@(posedge clock) disable iff (sys_rst)
        $rose(fullFeatures_r) |-> $past(writeCommit && !wrAddrCycle_r
                                        && pointer_r == {4'h0, `LOC_FULL_FEATURES}))
        else $error("full features set without write");
    chk_buffer_only: assert property (@(posedge clock) disable iff (sys_rst)
        ramWrEn |-> pointer_r >= `BUFFER_FIRST)
        else $error("buffer write hit control space");
    chk_arm_clear: assert property (@(posedge clock) disable iff (sys_rst)
        (xferDoneA && !writeCommit) |=> !ctrlRegs_r[`LOC_CTRL_A][`ARM_BIT])
        else $error("arm not cleared on completion");
    chk_pll_select: assert property (@(posedge clock) disable iff (sys_rst)
        !clockFreqSelect |=> pllMultiplier_r == `PLL_MULT_48MHZ)
        else $error("wrong multiplier");
    chk_bus_drive: assert property (@(posedge clock) disable iff (sys_rst)
        readActive |=> !dataOeN_r)
        else $error("bus not driven in read");

endmodule // usb_host_cpu_bus_port

//--- tb/cpu_bus_model.sv
`timescale 1ns/1ps

module cpu_bus_model
    import usb_host_port_pkg::*;
(
    input  wire logic         clock,
    input  wire logic [7:0]   dataOut,
    input  wire logic         dataOeN,
    output cpu_pins_type      pins
);
    cpu_pins_type drv;
    logic [7:0]   lastData;

    // Wire level: the device wins while its enable is low
    always_comb begin
        pins = drv;
        pins.data = (dataOeN === 1'b0) ? dataOut : drv.data;
    end

    initial begin
        drv = '{1'b1, 1'b1, 1'b1, 1'b1, 8'h00};
        lastData = 8'h00;
    end

    // One byte; endSel chooses which line closes the cycle
    task automatic wr(input logic a0, input logic [7:0] d, input logic endSel);
        @(negedge clock);
        drv = '{1'b0, 1'b1, 1'b0, a0, d};
        @(negedge clock);
        if (endSel) drv.deviceSelectN = 1'b1;
        else drv.writeStrobeN = 1'b1;
        @(negedge clock);
        drv = '{1'b1, 1'b1, 1'b1, a0, ~d}; // Released: never the stale byte
        lastData = d;
        repeat (2) @(negedge clock);
    endtask

    // Strobe held three cycles to cover the buffer latency
    task automatic rd(output logic [7:0] d);
        @(negedge clock);
        drv = '{1'b0, 1'b0, 1'b1, 1'b1, ~lastData};
        repeat (3) @(negedge clock);
        d = (dataOeN === 1'b0) ? dataOut : 8'hxx;
        drv = '{1'b1, 1'b1, 1'b1, 1'b1, lastData};
        repeat (2) @(negedge clock);
    endtask
endmodule // cpu_bus_model

//--- tb/usb_host_cpu_bus_port_tb.sv
`timescale 1ns/1ps
`include "usb_host_port_regs.svh"

module usb_host_cpu_bus_port_tb;
    import usb_host_port_pkg::*;
    logic           clock;
    logic           sys_rst;
    cpu_pins_type   cpuPins;
    logic [7:0]     dataOut, rdByte, mask, ev, base, usbEvents, engineRdData;
    logic           dataOeN, irqOut, directAddrMode, clockFreqSelect, fullFeatures;
    logic           xferDoneA, xferDoneB;
    logic [2:0]     pllMult;
    engine_req_type engineReq;
    xfer_set_type   setA, setB;
    logic [7:0]     bytes [5];
    int             fail_count, total_checks, i, j;

    usb_host_cpu_bus_port dut_u (.clock(clock), .sys_rst(sys_rst), .cpuPins(cpuPins),
        .dataOut_r(dataOut), .dataOeN_r(dataOeN), .irqOut_r(irqOut),
        .directAddrMode(directAddrMode), .clockFreqSelect(clockFreqSelect),
        .pllMultiplier_r(pllMult), .usbEvents(usbEvents), .xferDoneA(xferDoneA),
        .xferDoneB(xferDoneB), .engineReq(engineReq), .engineRdData(engineRdData),
        .xferSetA_r(setA), .xferSetB_r(setB), .fullFeatures_r(fullFeatures));
    cpu_bus_model cpu_u (.clock(clock), .dataOut(dataOut), .dataOeN(dataOeN), .pins(cpuPins));

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            $display("ERROR %s expected %h seen %h", what, exp, seen);
            fail_count++;
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic wa(input logic [7:0] a);
        cpu_u.wr(1'b0, a, 1'($urandom));
    endtask

    task automatic wd(input logic [7:0] d);
        cpu_u.wr(1'b1, d, 1'($urandom));
    endtask

    function automatic logic expIrq(input logic [7:0] st, input logic [7:0] m);
        return |(st & m);
    endfunction

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    // Whole run is under a thousand cycles
    initial begin
        #200000;
        fail_count++;
        stop_test();
    end

    initial begin
        sys_rst = 1'b1;
        directAddrMode = 1'b0;
        clockFreqSelect = 1'b0;
        usbEvents = 8'h00;
        engineReq = '0;
        xferDoneA = 1'b0;
        xferDoneB = 1'b0;
        fail_count = 0;
        total_checks = 0;
        void'($urandom(32'hf38b2a7b));
        repeat (10) @(negedge clock);
        sys_rst = 1'b0;
        check("irq", {7'h0, irqOut}, 8'h00);
        check("oe", {7'h0, dataOeN}, 8'h01);
        check("pll", {5'h0, pllMult}, 8'h01);
        $display("reset test done");
        for (i = 0; i < 4; i++) begin
            base = (i == 0) ? 8'hfc : 8'h10 + 8'($urandom_range(0, 8'hdc));
            wa(base);
            for (j = 0; j < 4; j++) begin
                bytes[j] = 8'($urandom);
                wd(bytes[j]);
            end
            wa(base);
            for (j = 0; j < 4; j++) begin
                cpu_u.rd(rdByte);
                check("buffer", rdByte, bytes[j]);
            end
            if (i == 0) begin
                cpu_u.rd(rdByte);
                check("wrap", rdByte, 8'h00);
            end
        end
        $display("indexed test done");
        directAddrMode = 1'b1;
        bytes[0] = 8'($urandom);
        bytes[1] = ~bytes[0];
        wa(8'h20);
        wd(bytes[0]);
        wd(bytes[1]);
        cpu_u.rd(rdByte);
        check("direct", rdByte, bytes[1]);
        cpu_u.rd(rdByte);
        check("direct", rdByte, bytes[1]);
        directAddrMode = 1'b0;
        $display("direct test done");
        for (i = 0; i < 10; i++) begin
            mask = (i < 8) ? 8'h01 << i : 8'($urandom);
            ev = (i == 9) ? 8'hff : 8'($urandom);
            wa(8'h06);
            wd(mask);
            @(negedge clock);
            usbEvents = ev;
            @(negedge clock);
            usbEvents = 8'h00;
            repeat (3) @(negedge clock);
            check("irq", {7'h0, irqOut}, {7'h0, expIrq(ev, mask)});
            wa(8'h0d);
            cpu_u.rd(rdByte);
            check("status", rdByte, ev);
            wa(8'h0d);
            wd(ev);
            check("irq", {7'h0, irqOut}, 8'h00);
            wa(8'h0d);
            cpu_u.rd(rdByte);
            check("status", rdByte, 8'h00);
        end
        $display("interrupt test done");
        base = 8'h10 + 8'($urandom_range(0, 8'hef));
        wa(8'h01);
        wd(base);
        check("setA", setA.base, base);
        @(negedge clock);
        engineReq = '{1'b1, base, ~base};
        @(negedge clock);
        engineReq.wrEn = 1'b0;
        repeat (2) @(negedge clock);
        check("engine", engineRdData, ~base);
        wa(base);
        cpu_u.rd(rdByte);
        check("engbuf", rdByte, ~base);
        wa(8'h09);
        wd(base);
        check("setB", setB.base, 8'h00);
        wa(8'h0f);
        wd(8'($urandom));
        check("full", {7'h0, fullFeatures}, 8'h01);
        check("setB", setB.base, base);
        // Completion pulse drops only the arm bit, for set A then set B
        for (i = 0; i < 2; i++) begin
            mask = 8'($urandom) | 8'h01;
            wa(8'(i * 8));
            wd(mask);
            check("arm", (i == 1) ? setB.ctrl : setA.ctrl, mask);
            @(negedge clock);
            xferDoneA = (i == 0);
            xferDoneB = (i == 1);
            @(negedge clock);
            xferDoneA = 1'b0;
            xferDoneB = 1'b0;
            repeat (2) @(negedge clock);
            check("done", (i == 1) ? setB.ctrl : setA.ctrl, mask & 8'hfe);
        end
        wa(8'h0e);
        cpu_u.rd(rdByte);
        check("rev", rdByte, `HW_REVISION);
        $display("engine test done");
        clockFreqSelect = 1'b1;
        repeat (3) @(negedge clock);
        check("pll", {5'h0, pllMult}, 8'h04);
        clockFreqSelect = 1'b0;
        repeat (3) @(negedge clock);
        check("pll", {5'h0, pllMult}, 8'h01);
        $display("clock test done");
        stop_test();
    end
endmodule // usb_host_cpu_bus_port_tb
